// >>> hdl/usbc_pkg.sv
// shared constants for the baud control bit block
package usbc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_DIVISOR = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0C;
    localparam logic [7:0] OFS_MEASURE = 8'h10;
    // control field positions
    localparam int unsigned CTRL_AUTO_POS = 0;
    localparam int unsigned CTRL_WAKE_POS = 1;
    localparam int unsigned CTRL_WIDE_POS = 3;
    localparam int unsigned CTRL_POL_POS  = 4;
    localparam int unsigned CTRL_SYNC_POS = 6;
    localparam logic [31:0] CTRL_MASK     = 32'h0000005B;
    // status and mask field positions
    localparam int unsigned ST_RX_POS   = 0;
    localparam int unsigned ST_AUTO_POS = 1;
    localparam int unsigned ST_WAKE_POS = 2;
    localparam int unsigned ST_WIDTH    = 3;
    // reset values
    localparam logic [31:0] CTRL_RESET    = 32'h00000000;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [2:0]  MASK_RESET    = 3'h0;
    // auto rate measurement limits
    localparam int unsigned MEASURE_WIDTH = 16;
endpackage

// >>> hdl/usbc_rate_gen.sv
// baud rate generator with 8-bit or 16-bit divisor
`timescale 1ns/1ps
`default_nettype none
module usbc_rate_gen #(
    parameter int unsigned DIV_WIDTH = 16
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 run,
    input  wire logic                 wide_rate_generator_select,
    input  wire logic [DIV_WIDTH-1:0] divisor,
    output logic                      rate_tick
);
    logic [DIV_WIDTH-1:0] count;
    logic [DIV_WIDTH-1:0] load_value;
    logic                 at_zero;

    // narrow mode uses only the low byte of the divisor
    always_comb begin
        load_value = divisor;
        if (!wide_rate_generator_select) begin
            load_value = {{(DIV_WIDTH-8){1'b0}}, divisor[7:0]};
        end
    end

    assign at_zero = (count == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!run || at_zero) begin
            count <= load_value;
        end else if (!wide_rate_generator_select) begin
            count <= {{(DIV_WIDTH-8){1'b0}}, count[7:0] - 8'h01};
        end else begin
            count <= count - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_tick <= 1'b0;
        end else begin
            rate_tick <= run && at_zero;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/usbc_auto_meter.sv
// measures the low time of a start bit for automatic rate detection
`timescale 1ns/1ps
`default_nettype none
module usbc_auto_meter #(
    parameter int unsigned CNT_WIDTH = 16
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 arm,
    input  wire logic                 rx_fall,
    input  wire logic                 rx_rise,
    output logic                      busy,
    output logic                      done,
    output logic [CNT_WIDTH-1:0]      measured
);
    logic [CNT_WIDTH-1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
        end else if (!arm) begin
            busy <= 1'b0;
        end else if (!busy && rx_fall) begin
            busy <= 1'b1;
        end else if (busy && rx_rise) begin
            busy <= 1'b0;
        end
    end

    // saturating count of the low time; the edge cycle counts as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!busy) begin
            count <= {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end else if (count != '1) begin
            count <= count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done     <= 1'b0;
            measured <= '0;
        end else begin
            done <= arm && busy && rx_rise;
            if (arm && busy && rx_rise) begin
                measured <= count;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/usbc_baud_ctrl.sv
// baud control bits: polarity, generator width, wake-up, auto rate detect
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module usbc_baud_ctrl
    import usbc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        tx_serial_data,
    input  wire logic        tx_sync_clock,
    input  wire logic        tx_sync_clock_drive,
    input  wire logic        rx_pin,
    input  wire logic        rx_char_done,
    input  wire logic        transmit_clock_pin_in,
    output logic             transmit_clock_pin_out,
    output logic             transmit_clock_pin_oe_n,
    output logic             sync_data_strobe,
    output logic             receiver_active,
    output logic             rate_tick,
    output logic             receive_event_flag,
    output logic             irq
);
    logic [31:0]              ctrl;
    logic [15:0]              divisor;
    logic [ST_WIDTH-1:0]      status;
    logic [ST_WIDTH-1:0]      mask;
    logic                     tx_clock_polarity_select;
    logic                     wide_rate_generator_select;
    logic                     edge_wakeup_enable;
    logic                     auto_rate_detect_enable;
    logic                     sync_mode;
    logic                     wake_active;
    logic                     auto_active;
    logic                     rx_prev;
    logic                     rx_fall;
    logic                     rx_rise;
    logic                     pin_prev;
    logic                     wake_hit;
    logic                     auto_done;
    logic                     auto_busy;
    logic [MEASURE_WIDTH-1:0] measured;
    logic                     wr_en;
    logic                     rd_en;
    logic                     addr_ok;
    logic [ST_WIDTH-1:0]      st_set;
    logic [ST_WIDTH-1:0]      st_clr;

    assign tx_clock_polarity_select   = ctrl[CTRL_POL_POS];
    assign wide_rate_generator_select = ctrl[CTRL_WIDE_POS];
    assign edge_wakeup_enable         = ctrl[CTRL_WAKE_POS];
    assign auto_rate_detect_enable    = ctrl[CTRL_AUTO_POS];
    assign sync_mode                  = ctrl[CTRL_SYNC_POS];

    // effective enables only exist in asynchronous mode
    assign wake_active = !sync_mode && edge_wakeup_enable;
    assign auto_active = !sync_mode && auto_rate_detect_enable;

    // apb slave, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_DIVISOR) ||
                     (paddr == OFS_STATUS) || (paddr == OFS_MASK) ||
                     (paddr == OFS_MEASURE);
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        prdata = 32'h00000000;
        unique case (paddr)
            OFS_CTRL:    prdata = ctrl;
            OFS_DIVISOR: prdata = {16'h0000, divisor};
            OFS_STATUS:  prdata = {{(32-ST_WIDTH){1'b0}}, status};
            OFS_MASK:    prdata = {{(32-ST_WIDTH){1'b0}}, mask};
            OFS_MEASURE: prdata = {{(32-MEASURE_WIDTH){1'b0}}, measured};
            default:     prdata = 32'h00000000;
        endcase
        if (!rd_en) begin
            prdata = 32'h00000000;
        end
    end

    // receive pin edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_pin;
        end
    end
    assign rx_fall = rx_prev && !rx_pin;
    assign rx_rise = !rx_prev && rx_pin;

    // wake-up: a falling edge while waiting, no character received
    assign wake_hit = wake_active && rx_fall;

    // receiver runs normally unless waiting for wake-up or measuring
    assign receiver_active = !wake_active && !auto_active;

    // control register; hardware clears of self-clearing bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else begin
            if (wr_en && paddr == OFS_CTRL) begin
                ctrl <= pwdata & CTRL_MASK;
            end else begin
                if (wake_hit) begin
                    ctrl[CTRL_WAKE_POS] <= 1'b0;
                end
                if (auto_done) begin
                    ctrl[CTRL_AUTO_POS] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= DIVISOR_RESET;
        end else if (wr_en && paddr == OFS_DIVISOR) begin
            divisor <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= MASK_RESET;
        end else if (wr_en && paddr == OFS_MASK) begin
            mask <= pwdata[ST_WIDTH-1:0];
        end
    end

    // sticky status, write one to clear, set wins
    always_comb begin
        st_set = '0;
        st_set[ST_RX_POS]   = wake_hit ||
                              (receiver_active && rx_char_done);
        st_set[ST_AUTO_POS] = auto_done;
        st_set[ST_WAKE_POS] = wake_hit;
        st_clr = '0;
        if (wr_en && paddr == OFS_STATUS) begin
            st_clr = pwdata[ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    assign receive_event_flag = status[ST_RX_POS];
    assign irq = |(status & mask);

    // generator: auto measurement holds it off in async mode
    usbc_rate_gen #(
        .DIV_WIDTH (16)
    ) u_rate_gen (
        .pclk                       (pclk),
        .presetn                    (presetn),
        .run                        (!auto_active),
        .wide_rate_generator_select (wide_rate_generator_select),
        .divisor                    (divisor),
        .rate_tick                  (rate_tick)
    );

    // measurement is armed only by the asynchronous auto-rate bit
    usbc_auto_meter #(
        .CNT_WIDTH (MEASURE_WIDTH)
    ) u_auto_meter (
        .pclk     (pclk),
        .presetn  (presetn),
        .arm      (auto_active),
        .rx_fall  (rx_fall),
        .rx_rise  (rx_rise),
        .busy     (auto_busy),
        .done     (auto_done),
        .measured (measured)
    );

    // transmit/clock pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_clock_pin_out  <= 1'b1;
            transmit_clock_pin_oe_n <= 1'b0;
        end else if (!sync_mode) begin
            transmit_clock_pin_out  <= tx_serial_data ^
                                       tx_clock_polarity_select;
            transmit_clock_pin_oe_n <= 1'b0;
        end else begin
            transmit_clock_pin_out  <= tx_sync_clock;
            transmit_clock_pin_oe_n <= !tx_sync_clock_drive;
        end
    end

    // sync clock edge selection from the polarity bit, edges seen at the pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= transmit_clock_pin_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_data_strobe <= 1'b0;
        end else if (tx_clock_polarity_select) begin
            sync_data_strobe <= sync_mode && !pin_prev &&
                                transmit_clock_pin_in;
        end else begin
            sync_data_strobe <= sync_mode && pin_prev &&
                                !transmit_clock_pin_in;
        end
    end
endmodule
`default_nettype wire

// >>> verification/usbc_baud_ctrl_properties.sv
// assertion checker for the baud control bit block
`timescale 1ns/1ps
`default_nettype none
module usbc_props
    import usbc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        tx_serial_data,
    input wire logic        tx_sync_clock_drive,
    input wire logic        rx_pin,
    input wire logic        transmit_clock_pin_in,
    input wire logic        transmit_clock_pin_out,
    input wire logic        transmit_clock_pin_oe_n,
    input wire logic        sync_data_strobe,
    input wire logic        receiver_active,
    input wire logic        receive_event_flag
);
    logic wr, pol, syn, wake, ab_en, rx_q, fall;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pwrite && paddr == OFS_CTRL;
    assign fall = wake && !syn && rx_q && !rx_pin && !wr;
    // shadow of the control bits as software wrote them; wake clears on a qualifying falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {syn, pol, wake, ab_en} <= 4'h0;
            rx_q <= 1'b1;
        end else begin
            rx_q <= rx_pin;
            if (wr) begin
                {syn, pol, wake, ab_en} <= {pwdata[6], pwdata[4], pwdata[1:0]};
            end else if (fall) begin
                wake <= 1'b0;
            end
        end
    end
    pin_data_a: assert property ($past(presetn) && !$past(syn) |->
        transmit_clock_pin_out == $past(tx_serial_data ^ pol))
        else $error("pin data");
    pin_drive_a: assert property ($past(presetn) |->
        transmit_clock_pin_oe_n ==
        ($past(syn) && !$past(tx_sync_clock_drive)))
        else $error("pin drive");
    strobe_edge_a: assert property (syn && $past(syn, 2) &&
        $past(transmit_clock_pin_in) != transmit_clock_pin_in &&
        transmit_clock_pin_in == pol |-> ##[1:3] sync_data_strobe)
        else $error("no strobe");
    wake_flag_a: assert property (fall |=> receive_event_flag)
        else $error("no wake flag");
    wake_clear_a: assert property (fall && !ab_en |=>
        receiver_active) else $error("wake not cleared");
    wake_off_a: assert property (wr && pwdata[1:0] == 2'h0 |=>
        receiver_active) else $error("receiver idle");
    auto_start_a: assert property (wr && pwdata[0] && !pwdata[6]
        |=> !receiver_active) else $error("auto not started");
    sync_ignore_a: assert property (wr && pwdata[6] |=>
        receiver_active [*3]) else $error("sync not ignored");
endmodule
bind usbc_baud_ctrl usbc_props i_props (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .tx_serial_data          (tx_serial_data),
    .tx_sync_clock_drive     (tx_sync_clock_drive),
    .rx_pin                  (rx_pin),
    .transmit_clock_pin_in   (transmit_clock_pin_in),
    .transmit_clock_pin_out  (transmit_clock_pin_out),
    .transmit_clock_pin_oe_n (transmit_clock_pin_oe_n),
    .sync_data_strobe        (sync_data_strobe),
    .receiver_active         (receiver_active),
    .receive_event_flag      (receive_event_flag)
);
`default_nettype wire

// >>> verification/usbc_peer.sv
// far-side peer: receive line and pin clock when the device lets go
`timescale 1ns/1ps
`default_nettype none
module usbc_peer (
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    input  wire logic rx_level,
    input  wire logic peer_clk,
    output logic      rx_pin,
    output logic      pin_in
);
    assign rx_pin = rx_level;
    // peer clocks the shared pin only while the device releases it
    assign pin_in = pin_oe_n ? peer_clk : pin_out;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// testbench for the baud control bit block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import usbc_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, txd = 1'b0, tsc = 1'b0, tscd = 1'b1;
    logic        rdone = 1'b0, rxl = 1'b1, pk = 1'b0, serr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv, g;
    logic        pready, pslverr, rx_pin, pin_in, pin_out, oe_n, strb;
    logic        ract, tick, flag, irq;
    int          num_errors = 0, checks = 0, cyc = 0;
    always #5 pclk = ~pclk;
    usbc_baud_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .tx_serial_data(txd), .tx_sync_clock(tsc), .tx_sync_clock_drive(tscd),
        .rx_pin(rx_pin), .rx_char_done(rdone), .transmit_clock_pin_in(pin_in),
        .transmit_clock_pin_out(pin_out), .transmit_clock_pin_oe_n(oe_n),
        .sync_data_strobe(strb), .receiver_active(ract), .rate_tick(tick),
        .receive_event_flag(flag), .irq(irq));
    usbc_peer i_peer (.pin_out(pin_out), .pin_oe_n(oe_n), .rx_level(rxl),
        .peer_clk(pk), .rx_pin(rx_pin), .pin_in(pin_in));
    task automatic complete_run;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            complete_run;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic strobes(input int n, output logic [31:0] c);
        c = 32'h0;
        repeat (n) begin
            @(posedge pclk);
            c = c + {31'h0, strb};
        end
    endtask
    task automatic gap;
        g = 32'h0;
        do @(posedge pclk); while (tick !== 1'b1);
        do begin
            @(posedge pclk);
            g = g + 32'h1;
        end while (tick !== 1'b1);
    endtask
    task automatic t_regs;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_DIVISOR, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(OFS_MEASURE, 32'h0);
        wr(OFS_MEASURE, 32'hFFFF);
        rd(OFS_MEASURE, 32'h0);
        wr(OFS_CTRL, 32'hFFFFFFFF);
        rd(OFS_CTRL, CTRL_MASK);
        chk1(serr, 1'b0);
        wr(OFS_CTRL, 32'h0);
        rd(8'h14, 32'h0);
        chk1(serr, 1'b1);
        $display("regs end");
    endtask
    task automatic t_pol;
        for (int p = 0; p < 2; p++) begin
            wr(OFS_CTRL, p ? 32'h10 : 32'h0);
            for (int d = 0; d < 2; d++) begin
                txd <= d[0];
                idle(3);
                chk1(pin_out, d[0] ^ p[0]);
            end
        end
        $display("pol end");
    endtask
    task automatic t_sync;
        logic [31:0] c;
        tscd <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            pk <= 1'b0;
            wr(OFS_CTRL, p ? 32'h50 : 32'h40);
            strobes(4, c);
            pk <= 1'b1;
            strobes(6, c);
            chk(c, p);
            pk <= 1'b0;
            strobes(6, c);
            chk(c, 1 - p);
        end
        tscd <= 1'b1;
        tsc <= 1'b1;
        idle(3);
        chk1(pin_out, 1'b1);
        wr(OFS_CTRL, 32'h0);
        $display("sync end");
    endtask
    task automatic t_rate;
        wr(OFS_DIVISOR, 32'h0102);
        wr(OFS_CTRL, 32'h08);
        gap;
        chk(g, 32'h103);
        wr(OFS_CTRL, 32'h0);
        gap;
        chk(g, 32'h3);
        $display("rate end");
    endtask
    task automatic t_wake;
        wr(OFS_MASK, 32'h4);
        wr(OFS_CTRL, 32'h02);
        idle(1);
        chk1(ract, 1'b0);
        rdone <= 1'b1;
        idle(1);
        rdone <= 1'b0;
        idle(1);
        chk1(flag, 1'b0);
        rxl <= 1'b0;
        idle(2);
        chk1(flag, 1'b1);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h5);
        chk1(irq, 1'b1);
        wr(OFS_STATUS, 32'h7);
        rxl <= 1'b1;
        idle(2);
        chk1(irq, 1'b0);
        wr(OFS_CTRL, 32'h0);
        rxl <= 1'b0;
        idle(2);
        chk1(flag, 1'b0);
        rxl <= 1'b1;
        rdone <= 1'b1;
        idle(1);
        rdone <= 1'b0;
        idle(1);
        chk1(flag, 1'b1);
        wr(OFS_STATUS, 32'h7);
        $display("wake end");
    endtask
    task automatic t_auto;
        wr(OFS_MASK, 32'h2);
        wr(OFS_CTRL, 32'h01);
        idle(1);
        chk1(ract, 1'b0);
        rxl <= 1'b0;
        idle(8);
        rxl <= 1'b1;
        idle(4);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_MEASURE, 32'h8);
        chk1(irq, 1'b1);
        chk1(ract, 1'b1);
        wr(OFS_STATUS, 32'h7);
        $display("auto end");
    endtask
    task automatic t_ign;
        wr(OFS_CTRL, 32'h43);
        idle(1);
        chk1(ract, 1'b1);
        rxl <= 1'b0;
        idle(12);
        rxl <= 1'b1;
        chk1(flag, 1'b0);
        gap;
        chk(g, 32'h3);
        rd(OFS_CTRL, 32'h43);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MEASURE, 32'h8);
        wr(OFS_CTRL, 32'h0);
        $display("sync ignore end");
    endtask
    initial begin
        idle(4);
        presetn <= 1'b1;
        t_regs;
        t_pol;
        t_sync;
        t_rate;
        t_wake;
        t_auto;
        t_ign;
        complete_run;
    end
endmodule
`default_nettype wire
